// [src/stc_defs.vh]
// constants for the trigger and acquisition sequencing controller
`ifndef STC_DEFS_VH
`define STC_DEFS_VH
`define STC_A_CTRL      8'h00
`define STC_A_CMD       8'h04
`define STC_A_LEVEL     8'h08
`define STC_A_RECLEN    8'h0c
`define STC_A_POS       8'h10
`define STC_A_HOLD      8'h14
`define STC_A_TB        8'h18
`define STC_A_DTIME     8'h1c
`define STC_A_DCNT      8'h20
`define STC_A_STATUS    8'h24
`define STC_A_TADDR     8'h28
`define STC_C_AUTO      0
`define STC_C_SINGLE    1
`define STC_C_ROLL      2
`define STC_C_FALL      3
`define STC_C_DTIME     4
`define STC_C_DEVT      5
`define STC_C_SRC_LO    6
`define STC_C_VIDEO     8
`define STC_C_VNEG      9
`define STC_C_FLD_LO    10
`define STC_K_RUN       0
`define STC_K_STOP      1
`define STC_K_FORCE     2
`define STC_K_SSEQ      3
`define STC_SRC_CH0     2'h0
`define STC_SRC_CH1     2'h1
`define STC_SRC_LINE    2'h2
`define STC_SRC_EXT     2'h3
`define STC_FLD_ONE     2'h0
`define STC_FLD_TWO     2'h1
`define STC_RST_RECLEN  15'h01f4
`define STC_RST_POS     7'h32
`define STC_RST_TB      16'h0001
`define STC_RST_LEVEL   16'h8080
`define STC_PCT_FULL    7'h64
`define STC_AUTO_MULT   32'h0000_1000
`define STC_HO_MIN_K    32'h0000_0004
`define STC_HO_SPAN_K   32'h0000_0400
`define STC_CLK_HZ      200000000
`define STC_LINE_HZ     60
`define STC_RESP_OK     2'h0
`define STC_RESP_ERR    2'h2
`endif

// [src/stc_trigger.v]
// trigger and acquisition sequencing controller with axi4-lite registers
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`include "stc_defs.vh"
module stc_trigger #(
    parameter LINE_HALF = `STC_CLK_HZ / (2 * `STC_LINE_HZ)
) (
    input  wire        clock,
    input  wire        srst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  ch0_sample,
    input  wire [7:0]  ch1_sample,
    input  wire        external_trigger_input,
    input  wire        video_sync_in,
    input  wire        video_field_in,
    output wire        rec_we,
    output wire [14:0] rec_addr,
    output wire [15:0] rec_data,
    output wire        rec_done,
    output wire        arm_ind,
    output wire        ready_ind,
    output wire        posttrigger_fill_indicator
);
    localparam ST_STOP = 6'h01;
    localparam ST_PRE  = 6'h02;
    localparam ST_RDY  = 6'h04;
    localparam ST_DLY  = 6'h08;
    localparam ST_POST = 6'h10;
    localparam ST_HOLD = 6'h20;

    reg [5:0]  st_reg;
    reg [15:0] ctrl_reg;
    reg [15:0] level_reg;
    reg [14:0] reclen_reg;
    reg [6:0]  pos_reg;
    reg [6:0]  hold_reg;
    reg [15:0] tb_reg;
    reg [31:0] dtime_reg;
    reg [15:0] dcnt_reg;
    reg [14:0] taddr_reg;
    reg [7:0]  awa_reg;
    reg        awf_reg;
    reg [31:0] wd_reg;
    reg [3:0]  ws_reg;
    reg        wf_reg;
    reg        bv_reg;
    reg [1:0]  br_reg;
    reg        rv_reg;
    reg [31:0] rd_reg;
    reg [1:0]  rr_reg;
    reg        run_p;
    reg        stop_p;
    reg        force_p;
    reg        sseq_p;

    // bus slave: address and data taken in either order, one write at a time
    wire wr_go = awf_reg & wf_reg & ~bv_reg;
    assign s_axi_awready = ~awf_reg;
    assign s_axi_wready  = ~wf_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = ~rv_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;

    wire [31:0] wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}},
                         {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    wire [31:0] wval = wd_reg & wmask;
    wire [6:0]  wpct = (wval[6:0] > `STC_PCT_FULL) ? `STC_PCT_FULL
                                                     : wval[6:0];
    reg wmap;
    always @* begin
        case (awa_reg)
            `STC_A_CTRL, `STC_A_CMD, `STC_A_LEVEL, `STC_A_RECLEN,
            `STC_A_POS, `STC_A_HOLD, `STC_A_TB, `STC_A_DTIME,
            `STC_A_DCNT: wmap = 1'b1;
            default: wmap = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        run_p   <= 1'b0;
        stop_p  <= 1'b0;
        force_p <= 1'b0;
        sseq_p  <= 1'b0;
        if (srst) begin
            awf_reg    <= 1'b0;
            wf_reg     <= 1'b0;
            bv_reg     <= 1'b0;
            br_reg     <= `STC_RESP_OK;
            awa_reg    <= 8'h00;
            wd_reg     <= 32'h0000_0000;
            ws_reg     <= 4'h0;
            ctrl_reg   <= 16'h0000;
            level_reg  <= `STC_RST_LEVEL;
            reclen_reg <= `STC_RST_RECLEN;
            pos_reg    <= `STC_RST_POS;
            hold_reg   <= 7'h00;
            tb_reg     <= `STC_RST_TB;
            dtime_reg  <= 32'h0000_0000;
            dcnt_reg   <= 16'h0000;
        end else begin
            if (s_axi_awvalid & ~awf_reg) begin
                awa_reg <= s_axi_awaddr;
                awf_reg <= 1'b1;
            end
            if (s_axi_wvalid & ~wf_reg) begin
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
                wf_reg <= 1'b1;
            end
            if (bv_reg & s_axi_bready)
                bv_reg <= 1'b0;
            if (wr_go) begin
                awf_reg <= 1'b0;
                wf_reg  <= 1'b0;
                bv_reg  <= 1'b1;
                br_reg  <= wmap ? `STC_RESP_OK : `STC_RESP_ERR;
                case (awa_reg)
                    `STC_A_CTRL:   ctrl_reg   <= wval[15:0];
                    `STC_A_LEVEL:  level_reg  <= wval[15:0];
                    `STC_A_RECLEN: reclen_reg <= (wval[14:0] == 15'h0000)
                                                 ? 15'h0001 : wval[14:0];
                    `STC_A_POS:    pos_reg    <= wpct;
                    `STC_A_HOLD:   hold_reg   <= wpct;
                    `STC_A_TB:     tb_reg     <= (wval[15:0] == 16'h0000)
                                                 ? 16'h0001 : wval[15:0];
                    `STC_A_DTIME:  dtime_reg  <= wval;
                    `STC_A_DCNT:   dcnt_reg   <= wval[15:0];
                    `STC_A_CMD: begin
                        run_p   <= wval[`STC_K_RUN];
                        stop_p  <= wval[`STC_K_STOP];
                        force_p <= wval[`STC_K_FORCE];
                        sseq_p  <= wval[`STC_K_SSEQ];
                    end
                    default: ;
                endcase
            end
        end
    end

    always @(posedge clock) begin
        if (srst) begin
            rv_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            rr_reg <= `STC_RESP_OK;
        end else if (rv_reg) begin
            if (s_axi_rready)
                rv_reg <= 1'b0;
        end else if (s_axi_arvalid) begin
            rv_reg <= 1'b1;
            rr_reg <= `STC_RESP_OK;
            case (s_axi_araddr)
                `STC_A_CTRL:   rd_reg <= {16'h0000, ctrl_reg};
                `STC_A_CMD:    rd_reg <= 32'h0000_0000;
                `STC_A_LEVEL:  rd_reg <= {16'h0000, level_reg};
                `STC_A_RECLEN: rd_reg <= {17'h00000, reclen_reg};
                `STC_A_POS:    rd_reg <= {25'h0000000, pos_reg};
                `STC_A_HOLD:   rd_reg <= {25'h0000000, hold_reg};
                `STC_A_TB:     rd_reg <= {16'h0000, tb_reg};
                `STC_A_DTIME:  rd_reg <= dtime_reg;
                `STC_A_DCNT:   rd_reg <= {16'h0000, dcnt_reg};
                `STC_A_STATUS: rd_reg <= {23'h000000, st_reg,
                                          posttrigger_fill_indicator,
                                          ready_ind, arm_ind};
                `STC_A_TADDR:  rd_reg <= {17'h00000, taddr_reg};
                default: begin
                    rd_reg <= 32'h0000_0000;
                    rr_reg <= `STC_RESP_ERR;
                end
            endcase
        end
    end

    // pin inputs pass two flip-flops
    reg [1:0] ext_s;
    reg [1:0] vs_s;
    reg [1:0] vf_s;
    always @(posedge clock) begin
        if (srst) begin
            ext_s <= 2'h0;
            vs_s  <= 2'h0;
            vf_s  <= 2'h0;
        end else begin
            ext_s <= {ext_s[0], external_trigger_input};
            vs_s  <= {vs_s[0], video_sync_in};
            vf_s  <= {vf_s[0], video_field_in};
        end
    end

    // internal line-frequency square wave
    reg [31:0] line_cnt;
    reg        line_sq;
    always @(posedge clock) begin
        if (srst) begin
            line_cnt <= 32'h0000_0000;
            line_sq  <= 1'b0;
        end else if (line_cnt == LINE_HALF - 1) begin
            line_cnt <= 32'h0000_0000;
            line_sq  <= ~line_sq;
        end else begin
            line_cnt <= line_cnt + 32'h0000_0001;
        end
    end

    // sample tick from the time base divider
    reg [15:0] tb_cnt;
    wire       tick = (tb_cnt == 16'h0000);
    always @(posedge clock) begin
        if (srst)
            tb_cnt <= 16'h0000;
        else
            tb_cnt <= tick ? tb_reg - 16'h0001 : tb_cnt - 16'h0001;
    end

    wire [1:0] src   = ctrl_reg[`STC_C_SRC_LO+1:`STC_C_SRC_LO];
    wire       video = ctrl_reg[`STC_C_VIDEO];
    wire       fall  = ctrl_reg[`STC_C_FALL];
    wire [1:0] fld   = ctrl_reg[`STC_C_FLD_LO+1:`STC_C_FLD_LO];
    wire       analog = ~video & ~src[1];
    // chosen channel used regardless of display
    wire [7:0] smp = (src == `STC_SRC_CH0) ? ch0_sample : ch1_sample;
    wire       dig = video ? (vs_s[1] ^ ctrl_reg[`STC_C_VNEG])
                 : (src == `STC_SRC_LINE) ? line_sq : ext_s[1];
    wire fld_ok = (fld == `STC_FLD_ONE) ? ~vf_s[1]
                : (fld == `STC_FLD_TWO) ? vf_s[1] : 1'b1;
    wire upd = analog ? tick : 1'b1;
    wire m_cur = analog ? (smp >= level_reg[7:0]) : dig;
    wire d_cur = analog ? (smp >= level_reg[15:8]) : dig;
    reg  m_prev;
    reg  d_prev;
    always @(posedge clock) begin
        if (srst) begin
            m_prev <= 1'b0;
            d_prev <= 1'b0;
        end else if (upd) begin
            m_prev <= m_cur;
            d_prev <= d_cur;
        end
    end
    wire edge_sel = video ? 1'b0 : fall;
    wire m_evt = upd & (edge_sel ? (m_prev & ~m_cur)
                                 : (~m_prev & m_cur))
               & (~video | fld_ok);
    wire d_evt = upd & (edge_sel ? (d_prev & ~d_cur)
                                 : (~d_prev & d_cur));

    // lengths derived from record length, position and time base
    wire [21:0] pre_prod = reclen_reg * pos_reg;
    wire [21:0] pre_q    = pre_prod / `STC_PCT_FULL;
    wire [14:0] pre_need = pre_q[14:0];
    wire [14:0] post_need = reclen_reg - pre_need;
    wire [31:0] auto_to = {16'h0000, tb_reg} * `STC_AUTO_MULT;
    wire [31:0] ho_pct = (`STC_HO_SPAN_K * {25'h0000000, hold_reg})
                         / `STC_PCT_FULL;
    wire [31:0] ho_need = {16'h0000, tb_reg} * (`STC_HO_MIN_K + ho_pct);

    reg [14:0] wa_reg;
    reg [14:0] pre_cnt;
    reg [14:0] post_cnt;
    reg [31:0] auto_cnt;
    reg [31:0] ho_cnt;
    reg [31:0] dt_cnt;
    reg [15:0] de_cnt;
    reg        single_reg;
    reg        we_reg;
    reg [14:0] ra_reg;
    reg [15:0] rdat_reg;
    reg        done_reg;

    wire auto_md = ctrl_reg[`STC_C_AUTO];
    wire roll    = ctrl_reg[`STC_C_ROLL];
    wire dt_en   = ctrl_reg[`STC_C_DTIME];
    wire de_en   = ctrl_reg[`STC_C_DEVT];
    wire auto_fire = auto_md & (auto_cnt >= auto_to);
    wire untrig = auto_md & roll;
    wire rdy_go = m_evt | auto_fire | untrig;
    wire dly_on = dt_en | de_en;
    wire dly_ok = (~dt_en | (dt_cnt >= dtime_reg))
                & (~de_en | (de_cnt >= dcnt_reg));
    wire wr_on = (st_reg == ST_PRE) | (st_reg == ST_RDY)
               | (st_reg == ST_DLY) | (st_reg == ST_POST);
    wire samp = wr_on & tick;
    wire pre_end = (pre_cnt >= pre_need) | (samp & (pre_cnt + 15'h0001 >= pre_need));
    wire post_end = (post_cnt >= post_need) | (samp & (post_cnt + 15'h0001 >= post_need));
    reg [5:0] st_next;
    always @* begin
        st_next = st_reg;
        case (st_reg)
            ST_STOP: if (run_p | sseq_p) st_next = ST_PRE;
            ST_PRE: begin
                if (force_p) st_next = ST_POST;
                else if (pre_end) st_next = ST_RDY;
            end
            ST_RDY: begin
                if (force_p) st_next = ST_POST;
                else if (rdy_go) st_next = (dly_on & ~untrig) ? ST_DLY
                                                              : ST_POST;
            end
            ST_DLY: if (force_p | dly_ok) st_next = ST_POST;
            ST_POST: if (post_end) st_next = single_reg ? ST_STOP
                                                        : ST_HOLD;
            ST_HOLD: if (ho_cnt >= ho_need) st_next = ST_PRE;
            default: st_next = ST_STOP;
        endcase
        if (stop_p) st_next = ST_STOP;
    end

    always @(posedge clock) begin
        if (srst) begin
            st_reg     <= ST_STOP;
            wa_reg     <= 15'h0000;
            pre_cnt    <= 15'h0000;
            post_cnt   <= 15'h0000;
            auto_cnt   <= 32'h0000_0000;
            ho_cnt     <= 32'h0000_0000;
            dt_cnt     <= 32'h0000_0000;
            de_cnt     <= 16'h0000;
            taddr_reg  <= 15'h0000;
            single_reg <= 1'b0;
            we_reg     <= 1'b0;
            ra_reg     <= 15'h0000;
            rdat_reg   <= 16'h0000;
            done_reg   <= 1'b0;
        end else begin
            st_reg   <= st_next;
            we_reg   <= samp;
            done_reg <= (st_reg == ST_POST) & post_end;
            if (sseq_p)
                single_reg <= 1'b1;
            else if (run_p)
                single_reg <= ctrl_reg[`STC_C_SINGLE];
            // circular record write keeps the newest samples
            if (samp) begin
                ra_reg   <= wa_reg;
                rdat_reg <= {ch1_sample, ch0_sample};
                wa_reg   <= (wa_reg >= reclen_reg - 15'h0001)
                            ? 15'h0000 : wa_reg + 15'h0001;
            end
            if (st_reg == ST_PRE) begin
                if (samp & (pre_cnt < pre_need))
                    pre_cnt <= pre_cnt + 15'h0001;
            end else begin
                pre_cnt <= 15'h0000;
            end
            // timer restarts on every detected event
            if (m_evt | (st_reg != ST_RDY) | auto_fire)
                auto_cnt <= 32'h0000_0000;
            else
                auto_cnt <= auto_cnt + 32'h0000_0001;
            if ((st_reg != ST_POST) & (st_next == ST_POST))
                taddr_reg <= wa_reg;
            if (st_reg == ST_POST) begin
                if (samp)
                    post_cnt <= post_cnt + 15'h0001;
            end else begin
                post_cnt <= 15'h0000;
            end
            if (st_reg == ST_HOLD)
                ho_cnt <= ho_cnt + 32'h0000_0001;
            else
                ho_cnt <= 32'h0000_0000;
            if (st_reg == ST_DLY) begin
                dt_cnt <= dt_cnt + 32'h0000_0001;
                if (d_evt)
                    de_cnt <= de_cnt + 16'h0001;
            end else begin
                dt_cnt <= 32'h0000_0000;
                de_cnt <= 16'h0000;
            end
        end
    end

    // events outside ready are dropped: lockout and holdoff
    assign arm_ind = (st_reg == ST_PRE);
    assign ready_ind = (st_reg == ST_RDY) | (st_reg == ST_DLY);
    assign posttrigger_fill_indicator = (st_reg == ST_POST)
                                      | (st_reg == ST_DLY);
    assign rec_we   = we_reg;
    assign rec_addr = ra_reg;
    assign rec_data = rdat_reg;
    assign rec_done = done_reg;
endmodule // stc_trigger

// [tb/stc_chan_model.sv]
// far-side model: channel sample words and acquisition record memory
`timescale 1ns/10ps
module stc_chan_model (
    input  wire        clock,
    input  wire [7:0]  lvl0,
    input  wire [7:0]  lvl1,
    input  wire        rec_we,
    input  wire [14:0] rec_addr,
    input  wire [15:0] rec_data,
    output reg  [7:0]  ch0_sample = 8'h00,
    output reg  [7:0]  ch1_sample = 8'h00
);
    reg [15:0] mem [0:31];
    // converters deliver a fresh word every clock; the record keeps what is written
    always @(posedge clock) begin
        ch0_sample <= lvl0;
        ch1_sample <= lvl1;
        if (rec_we) mem[rec_addr[4:0]] <= rec_data;
    end
endmodule // stc_chan_model

// [tb/stc_trigger_asserts.sv]
// port-level checks for the trigger controller
`timescale 1ns/10ps
module stc_trigger_asserts (
    input wire clock,
    input wire srst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire rec_we,
    input wire rec_done,
    input wire arm_ind,
    input wire ready_ind,
    input wire posttrigger_fill_indicator
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence idle_s;
        !arm_ind && !ready_ind && !posttrigger_fill_indicator;
    endsequence
    sequence wr_take_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer not one cycle after address");
    a_write_latency: assert property (wr_take_s |=> ##1 s_axi_bvalid)
        else $error("write answer not two cycles after request");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_ind_excl: assert property (arm_ind |-> !ready_ind && !posttrigger_fill_indicator)
        else $error("pretrigger indicator with another indicator");
    a_we_active: assert property (rec_we |->
        $past(arm_ind || ready_ind || posttrigger_fill_indicator))
        else $error("record write outside acquisition");
    a_done_post: assert property (rec_done |-> $past(posttrigger_fill_indicator))
        else $error("done without posttrigger fill");
    a_holdoff_idle: assert property (rec_done |-> ##[0:1] idle_s ##1 idle_s [*3])
        else $error("holdoff shorter than minimum");
    a_post_entry: assert property ($rose(posttrigger_fill_indicator) |->
        $past(ready_ind || arm_ind))
        else $error("trigger accepted outside armed states");
endmodule // stc_trigger_asserts
bind stc_trigger stc_trigger_asserts stc_trigger_asserts_inst (
    .clock(clock), .srst(srst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .rec_we(rec_we), .rec_done(rec_done), .arm_ind(arm_ind),
    .ready_ind(ready_ind), .posttrigger_fill_indicator(posttrigger_fill_indicator)
);

// [tb/stc_trigger_bench.sv]
// self-checking bench for the trigger controller
`timescale 1ns/10ps
`include "stc_defs.vh"
module stc_trigger_bench;
    localparam [7:0] LO = 8'h10;
    localparam [7:0] HI = 8'ha0;
    reg         clock = 1'b0, srst = 1'b1, vfield = 1'b0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00, t0 = LO, t1 = LO;
    reg         ext = 1'b0, vsync = 1'b0, arm_d = 1'b0, post_d = 1'b0;
    reg  [15:0] ch_d = 16'h0000;
    reg  [14:0] a_d = 15'h0013, lp = 15'h0000;
    reg  [31:0] wdata = 32'h0, d;
    reg  [1:0]  r;
    reg  [74:0] row [0:10];
    wire        awready, wready, bvalid, arready, rvalid, rec_we, rec_done, arm, rdy, post;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  ch0, ch1;
    wire [14:0] rec_addr;
    wire [15:0] rec_data;
    wire [3:0]  st = {rec_done, post, rdy, arm};
    integer     err_count = 0, num_checks = 0, pre_n = 0, post_n = 0, i;
    stc_trigger #(.LINE_HALF(50)) stc_trigger_inst (
        .clock(clock), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ch0_sample(ch0), .ch1_sample(ch1), .external_trigger_input(ext),
        .video_sync_in(vsync), .video_field_in(vfield), .rec_we(rec_we), .rec_addr(rec_addr),
        .rec_data(rec_data), .rec_done(rec_done), .arm_ind(arm), .ready_ind(rdy),
        .posttrigger_fill_indicator(post));
    stc_chan_model stc_chan_model_inst (.clock(clock), .lvl0(t0), .lvl1(t1), .rec_we(rec_we),
        .rec_addr(rec_addr), .rec_data(rec_data), .ch0_sample(ch0), .ch1_sample(ch1));
    initial begin
        forever #2.5 clock = ~clock;
    end
    // a write lands one cycle after its tick, so judge it by the state one cycle back
    always @(posedge clock) begin
        arm_d <= arm;
        post_d <= post & ~rdy;
        if (rec_we && arm_d) pre_n <= pre_n + 1;
        if (rec_we && post_d) post_n <= post_n + 1;
        if (rec_we && post_d) lp <= rec_addr;
        if (rec_we) a_d <= rec_addr;
        if (rec_we) chk_d({16'h0000, rec_data}, {16'h0000, ch_d});
        if (rec_we) chk_d({17'h00000, rec_addr}, (a_d == 15'h0013) ? 32'h0 : a_d + 32'h1);
        ch_d <= {ch1, ch0};
    end
    task give_verdict;
        begin
            $display("checks %0d errors %0d", num_checks, err_count);
            if (err_count == 0 && num_checks > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task chk_d(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task watch(input [3:0] m, input [3:0] v, input integer lim, input want);
        integer n;
        reg     hit;
        begin
            hit = 1'b0;
            for (n = 0; n < lim && !hit; n = n + 1) begin
                @(negedge clock);
                hit = ((st & m) === v);
            end
            chk_d({31'h0, hit}, {31'h0, want});
            if (want && !hit) give_verdict;
        end
    endtask
    task bus(input we, input [7:0] a, input [31:0] dv, output [31:0] dq, output [1:0] rs);
        integer n;
        reg     ah, wh, fin;
        begin
            @(posedge clock);
            awaddr <= a;
            araddr <= a;
            wdata <= dv;
            awvalid <= we;
            wvalid <= we;
            bready <= we;
            arvalid <= !we;
            rready <= !we;
            fin = 1'b0;
            for (n = 0; n < 50 && !fin; n = n + 1) begin
                @(negedge clock);
                ah = we ? awvalid & awready : arvalid & arready;
                wh = wvalid & wready;
                fin = we ? bvalid : rvalid;
                rs = we ? bresp : rresp;
                dq = rdata;
                @(posedge clock);
                if (ah && we) awvalid <= 1'b0;
                if (ah && !we) arvalid <= 1'b0;
                if (wh) wvalid <= 1'b0;
            end
            bready <= 1'b0;
            rready <= 1'b0;
            chk_d({31'h0, fin}, 32'h1);
            if (!fin) give_verdict;
        end
    endtask
    task wr(input [7:0] a, input [31:0] dv);
        bus(1'b1, a, dv, d, r);
    endtask
    // levels before the crossing, ctrl, wait ready, a quiet spell, then the crossing
    task edge_case(input [31:0] ctrl, input [18:0] a, input [18:0] b, input integer quiet);
        begin
            @(posedge clock);
            {vfield, vsync, ext, t1, t0} <= a;
            wr(`STC_A_CTRL, ctrl);
            watch(4'h2, 4'h2, 300, 1'b1);
            post_n = 0;
            if (quiet > 0) watch(4'h4, 4'h4, quiet, 1'b0);
            @(posedge clock);
            {vfield, vsync, ext, t1, t0} <= b;
            watch(4'h4, 4'h4, 300, 1'b1);
            watch(4'h8, 4'h8, 300, 1'b1);
            repeat (2) @(negedge clock);
            chk_d(post_n, 32'd14);
            bus(1'b0, `STC_A_TADDR, 32'h0, d, r);
            chk_d(d, (lp + 32'd6) % 32'd20);
        end
    endtask
    initial begin
        row[0] = {1'b0, `STC_A_LEVEL, 32'h0, 32'h8080, 2'h0};
        row[1] = {1'b0, `STC_A_RECLEN, 32'h0, 32'h1f4, 2'h0};
        row[2] = {1'b0, `STC_A_POS, 32'h0, 32'h32, 2'h0};
        row[3] = {1'b0, `STC_A_TB, 32'h0, 32'h1, 2'h0};
        row[4] = {1'b0, `STC_A_STATUS, 32'h0, 32'h8, 2'h0};
        row[5] = {1'b0, 8'h2c, 32'h0, 32'h0, 2'h2};
        row[6] = {1'b1, `STC_A_STATUS, 32'h0, 32'h8, 2'h2};
        row[7] = {1'b1, `STC_A_POS, 32'h7f, 32'h64, 2'h0};
        row[8] = {1'b1, `STC_A_POS, 32'h21, 32'h21, 2'h0};
        row[9] = {1'b1, `STC_A_RECLEN, 32'h14, 32'h14, 2'h0};
        row[10] = {1'b1, `STC_A_CMD, 32'h4, 32'h0, 2'h0};
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        for (i = 0; i < 11; i = i + 1) begin
            if (row[i][74]) bus(1'b1, row[i][73:66], row[i][65:34], d, r);
            if (row[i][74]) chk_d({30'h0, r}, {30'h0, row[i][1:0]});
            bus(1'b0, row[i][73:66], 32'h0, d, r);
            chk_d(d, row[i][33:2]);
            chk_d({30'h0, r}, row[i][74] ? 32'h0 : {30'h0, row[i][1:0]});
        end
        watch(4'h4, 4'h4, 60, 1'b0);
        wr(`STC_A_CTRL, 32'h0);
        pre_n = 0;
        wr(`STC_A_CMD, 32'h1);
        watch(4'h2, 4'h2, 300, 1'b1);
        repeat (2) @(negedge clock);
        chk_d(pre_n, 32'd6);
        edge_case(32'h0, {3'b000, LO, LO}, {3'b000, LO, HI}, 150);
        edge_case(32'h48, {3'b000, HI, HI}, {3'b000, LO, HI}, 150);
        edge_case(32'h80, {3'b000, LO, HI}, {3'b000, LO, HI}, 0);
        edge_case(32'hc0, {3'b000, LO, HI}, {3'b001, LO, HI}, 150);
        edge_case(32'h900, {3'b001, LO, HI}, {3'b011, LO, HI}, 150);
        edge_case(32'h700, {3'b111, LO, HI}, {3'b101, LO, HI}, 150);
        edge_case(32'h4, {3'b000, LO, LO}, {3'b000, LO, HI}, 150);
        edge_case(32'h5, {3'b000, LO, LO}, {3'b000, LO, LO}, 0);
        edge_case(32'h1, {3'b000, LO, LO}, {3'b000, LO, LO}, 4000);
        wr(`STC_A_CTRL, 32'h0);
        watch(4'h1, 4'h1, 300, 1'b1);
        wr(`STC_A_CMD, 32'h4);
        watch(4'h4, 4'h4, 20, 1'b1);
        watch(4'h8, 4'h8, 300, 1'b1);
        wr(`STC_A_DTIME, 32'd30);
        wr(`STC_A_HOLD, 32'h64);
        wr(`STC_A_CTRL, 32'h10);
        watch(4'h2, 4'h2, 300, 1'b1);
        @(posedge clock);
        t0 <= HI;
        watch(4'h6, 4'h6, 20, 1'b1);
        watch(4'h6, 4'h4, 25, 1'b0);
        watch(4'h6, 4'h4, 20, 1'b1);
        watch(4'h8, 4'h8, 100, 1'b1);
        watch(4'h1, 4'h1, 1000, 1'b0);
        watch(4'h1, 4'h1, 100, 1'b1);
        wr(`STC_A_HOLD, 32'h0);
        wr(`STC_A_CMD, 32'h8);
        edge_case(32'h2, {3'b000, LO, LO}, {3'b000, LO, HI}, 0);
        watch(4'h1, 4'h1, 200, 1'b0);
        wr(`STC_A_CMD, 32'h1);
        watch(4'h1, 4'h1, 300, 1'b1);
        @(posedge clock);
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        bus(1'b0, `STC_A_STATUS, 32'h0, d, r);
        chk_d(d, 32'h8);
        give_verdict;
    end
endmodule // stc_trigger_bench
